// [bench/pwm_capture_timer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_capture_timer_bench;
  logic        i_clk = 1'h0;
  logic        i_nrst = 1'h0;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic        trig = 1'h0;
  logic        halt = 1'h0;
  logic        step = 1'h0;
  logic        back = 1'h0;
  logic [3:2]  pins = 2'h0;
  logic [31:0] prd, q, v;
  logic        rdy, err, slv, tout, irq;
  logic [3:0]  cap, ch;
  logic [2:0]  chn;
  logic [4:0]  dma;
  logic [31:0] seed = 32'h0283;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  int          r, p, c, d, g, hi, lo, both;

  pwm_capture_timer dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(slv), .i_cap(cap), .i_trig_in(trig),
    .i_dbg_halt(halt), .o_ch(ch), .o_chn(chn), .o_trig_out(tout),
    .o_dma_req(dma), .o_irq(irq));
  quad_hall_source src (.i_clk(i_clk), .i_step(step), .i_back(back),
                        .i_pins(pins), .o_cap(cap));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // the run is under two thousand cycles; a hang stops well past that
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      close_out;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dd);
    @(posedge i_clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= dd;
    @(posedge i_clk);
    pen <= 1'h1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge i_clk);
    end while (rdy !== 1'h1);
    q = prd;
    err = slv;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic pulse(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (dma[0] !== 1'h1 && n < 3000);
    if (n >= 3000) failures++;
  endtask

  task automatic steps(input int k, input logic b);
    repeat (k) begin
      step <= 1'h1;
      back <= b;
      @(posedge i_clk);
      step <= 1'h0;
      repeat (5) @(posedge i_clk);
    end
  endtask

  // center mode turns at both ends, so one leg has reload ticks
  function automatic int period(input int m, rr, pp);
    return (m == 2 ? rr : rr + 1) * (pp + 1);
  endfunction

  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'h1;
    apb(0, pwm_capture_timer_pkg::OFF_RELOAD, 0);
    chk("reload", 32'h0000FFFF, q);
    apb(0, 8'h34, 0);
    chk("unmapped", 32'h0, q);
    chkb("slverr", 1'h1, err);
    apb(1, pwm_capture_timer_pkg::OFF_MASK, 1);
    apb(1, pwm_capture_timer_pkg::OFF_DMA, 1);
    for (int m = 0; m < 3; m++) begin
      p = $random(seed) & 3;
      r = 5 + ($random(seed) & 15);
      apb(1, pwm_capture_timer_pkg::OFF_PRESC, p);
      apb(1, pwm_capture_timer_pkg::OFF_RELOAD, r);
      apb(1, pwm_capture_timer_pkg::OFF_CTRL, 1 | (m << 1));
      pulse(g);
      pulse(g);
      chk("update gap", period(m, r, p), g);
      chkb("trig out", 1'h1, tout);
      chkb("irq update", 1'h1, irq);
    end
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 32'h108);
    // start from zero so the update cannot slip in before the wait
    apb(1, pwm_capture_timer_pkg::OFF_COUNT, 0);
    trig <= 1'h1;
    @(posedge i_clk);
    trig <= 1'h0;
    apb(0, pwm_capture_timer_pkg::OFF_CTRL, 0);
    chkb("trig start", 1'h1, q[0]);
    pulse(g);
    apb(0, pwm_capture_timer_pkg::OFF_CTRL, 0);
    chkb("one pulse stop", 1'h0, q[0]);
    v = $random(seed) & 32'hFFFF;
    halt <= 1'h1;
    apb(1, pwm_capture_timer_pkg::OFF_CHMODE, 0);
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 32'h11);
    apb(1, pwm_capture_timer_pkg::OFF_COUNT, v);
    pins <= 2'h2;
    apb(0, pwm_capture_timer_pkg::OFF_COUNT, 0);
    chk("frozen", v, q);
    apb(0, pwm_capture_timer_pkg::OFF_CCR3, 0);
    chk("capture", v, q);
    apb(0, pwm_capture_timer_pkg::OFF_STATUS, 0);
    chkb("cap flag", 1'h1, q[4]);
    halt <= 1'h0;
    r = 20 + ($random(seed) & 15);
    apb(1, pwm_capture_timer_pkg::OFF_PRESC, 0);
    apb(1, pwm_capture_timer_pkg::OFF_RELOAD, r);
    apb(1, pwm_capture_timer_pkg::OFF_CHMODE, 32'hA);
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? 0 : (k == 2) ? r + 1 : 8 + ($random(seed) & 7);
      d = (k == 3) ? 3 : 0;
      apb(1, pwm_capture_timer_pkg::OFF_DEAD, d);
      apb(1, pwm_capture_timer_pkg::OFF_CCR0, c);
      apb(1, pwm_capture_timer_pkg::OFF_CTRL, 1);
      repeat (r + 8) @(posedge i_clk);
      hi = 0;
      lo = 0;
      both = 0;
      repeat (r + 1) begin
        @(posedge i_clk);
        hi += ch[0];
        lo += !ch[0] && !chn[0];
        both += ch[0] && chn[0];
      end
      chk("pwm high", (c == 0) ? 0 : (c > r) ? r + 1 : c - d, hi);
      chk("dead", (c > 0 && c <= r) ? 2 * d : 0, lo);
      chk("overlap", 0, both);
    end
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 0);
    apb(1, pwm_capture_timer_pkg::OFF_RELOAD, 32'hFFFF);
    apb(1, pwm_capture_timer_pkg::OFF_COUNT, 0);
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 32'h41);
    g = 3 + ($random(seed) & 7);
    steps(g, 1'h0);
    apb(0, pwm_capture_timer_pkg::OFF_COUNT, 0);
    chk("enc up", g, q);
    steps(2, 1'h1);
    apb(0, pwm_capture_timer_pkg::OFF_COUNT, 0);
    chk("enc down", g - 2, q);
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 32'h80);
    apb(1, pwm_capture_timer_pkg::OFF_MASK, 0);
    apb(1, pwm_capture_timer_pkg::OFF_STATUS, 32'h7F);
    pins <= 2'h1;
    // two sync flops and the edge detect come before the restart
    repeat (4) @(posedge i_clk);
    apb(0, pwm_capture_timer_pkg::OFF_COUNT, 0);
    chk("hall reset", 0, q);
    apb(0, pwm_capture_timer_pkg::OFF_STATUS, 0);
    chkb("hall flag", 1'h1, q[6]);
    chkb("irq masked", 1'h0, irq);
    apb(1, pwm_capture_timer_pkg::OFF_MASK, 32'h40);
    apb(0, pwm_capture_timer_pkg::OFF_CCR0, 0);
    chk("hall latch", g - 2, q);
    chkb("irq on", 1'h1, irq);
    apb(1, pwm_capture_timer_pkg::OFF_STATUS, 32'h7F);
    apb(0, pwm_capture_timer_pkg::OFF_STATUS, 0);
    chk("status clear", 0, q);
    chkb("irq off", 1'h0, irq);
    // reduced variant ignores the center setting and gates ch2, ch3
    apb(1, pwm_capture_timer_pkg::OFF_DEAD, 0);
    apb(1, pwm_capture_timer_pkg::OFF_RELOAD, r);
    apb(1, pwm_capture_timer_pkg::OFF_CHMODE, 32'hAAA9);
    apb(1, pwm_capture_timer_pkg::OFF_DMA, 3);
    c = 8 + ($random(seed) & 7);
    apb(1, pwm_capture_timer_pkg::OFF_CCR0, c);
    apb(1, pwm_capture_timer_pkg::OFF_CCR1, c);
    apb(1, pwm_capture_timer_pkg::OFF_CCR2, r + 1);
    apb(1, pwm_capture_timer_pkg::OFF_CCR3, r + 1);
    apb(1, pwm_capture_timer_pkg::OFF_CTRL, 32'h25);
    pulse(g);
    pulse(g);
    chk("reduced gap", r + 1, g);
    lo = ch[0];
    hi = 0;
    d = 0;
    p = 0;
    both = 0;
    repeat (r + 1) begin
      @(posedge i_clk);
      hi += (ch[0] != lo);
      lo = ch[0];
      d += ch[1];
      p += dma[1];
      both += ch[2] | ch[3] | chn[1] | chn[2];
    end
    chk("compare toggles", 1, hi);
    chk("channel dma", 1, p);
    chk("reduced pwm", c, d);
    chk("reduced off", 0, both);
    // a second reset in mid-run must bring back the reset values
    i_nrst <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'h1;
    apb(0, pwm_capture_timer_pkg::OFF_CTRL, 0);
    chk("ctrl reset", 0, q);
    apb(0, pwm_capture_timer_pkg::OFF_RELOAD, 0);
    chk("reload reset", 32'h0000FFFF, q);
    chk("outputs reset", 0, {ch, chn, dma, irq});
    close_out;
  end
endmodule
`default_nettype wire

// [bench/quad_hall_source.sv]
`timescale 1ns/1ps
`default_nettype none
module quad_hall_source (
  input  wire logic       i_clk,
  input  wire logic       i_step,
  input  wire logic       i_back,
  input  wire logic [3:2] i_pins,
  output logic [3:0]      o_cap
);
  logic [1:0] ph = 2'h0;
  always_ff @(posedge i_clk) begin
    if (i_step) begin
      ph <= i_back ? ph - 2'h1 : ph + 2'h1;
    end
  end
  // gray order: one line moves per step, as on a real encoder
  assign o_cap = {i_pins, ph[1], ph[1] ^ ph[0]};
endmodule
`default_nettype wire

// [design/pwm_capture_timer.sv]
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pwm_capture_timer (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [3:0]  i_cap,
  input  wire logic        i_trig_in,
  input  wire logic        i_dbg_halt,
  output logic [3:0]       o_ch,
  output logic [2:0]       o_chn,
  output logic             o_trig_out,
  output logic [4:0]       o_dma_req,
  output logic             o_irq
);
  pwm_capture_timer_pkg::timer_state_t s;
  pwm_capture_timer_pkg::timer_state_t n;

  logic        wr;
  logic        cnt_wr;
  logic        frozen;
  logic        run;
  logic        tick;
  logic        upd_evt;
  logic        enc;
  logic        hall;
  logic        reduced;
  logic        enc_step;
  logic        enc_up;
  logic        hall_evt;
  logic        trig_evt;
  logic [1:0]  cmode;
  logic [3:0]  cap_evt;
  logic [3:0]  cc_set;
  logic [6:0]  st_set;
  logic [6:0]  st_clr;
  logic [31:0] rd;
  logic        hit;
  logic [1:0]  m;
  logic        pol;
  logic        oe;
  logic        lv;
  logic        rise;
  logic        fall;

  always_comb begin
    n = s;
    wr = i_psel & i_penable & i_pwrite;
    cnt_wr = wr && (i_paddr == pwm_capture_timer_pkg::OFF_COUNT);
    st_clr = 7'h00;
    // read data is caught in the setup phase so that prdata is a flop
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (i_paddr)
      pwm_capture_timer_pkg::OFF_CTRL:   rd = {23'h000000, s.ctrl};
      pwm_capture_timer_pkg::OFF_PRESC:  rd = {16'h0000, s.presc};
      pwm_capture_timer_pkg::OFF_RELOAD: rd = {16'h0000, s.reload};
      pwm_capture_timer_pkg::OFF_COUNT:  rd = {16'h0000, s.cnt};
      pwm_capture_timer_pkg::OFF_STATUS: rd = {25'h0000000, s.status};
      pwm_capture_timer_pkg::OFF_MASK:   rd = {25'h0000000, s.mask};
      pwm_capture_timer_pkg::OFF_DMA:    rd = {27'h0000000, s.dma};
      pwm_capture_timer_pkg::OFF_CHMODE: rd = {16'h0000, s.chmode};
      pwm_capture_timer_pkg::OFF_CCR0:   rd = {16'h0000, s.ccr[0]};
      pwm_capture_timer_pkg::OFF_CCR1:   rd = {16'h0000, s.ccr[1]};
      pwm_capture_timer_pkg::OFF_CCR2:   rd = {16'h0000, s.ccr[2]};
      pwm_capture_timer_pkg::OFF_CCR3:   rd = {16'h0000, s.ccr[3]};
      pwm_capture_timer_pkg::OFF_DEAD:   rd = {24'h000000, s.dead};
      default:                           hit = 1'b0;
    endcase
    if (i_psel & ~i_penable) begin
      n.rdata = rd;
      n.slverr = ~hit;
    end
    if (wr) begin
      case (i_paddr)
        pwm_capture_timer_pkg::OFF_CTRL:   n.ctrl = i_pwdata[8:0];
        pwm_capture_timer_pkg::OFF_PRESC:  n.presc = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_RELOAD: n.reload = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_STATUS: st_clr = i_pwdata[6:0];
        pwm_capture_timer_pkg::OFF_MASK:   n.mask = i_pwdata[6:0];
        pwm_capture_timer_pkg::OFF_DMA:    n.dma = i_pwdata[4:0];
        pwm_capture_timer_pkg::OFF_CHMODE: n.chmode = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_CCR0:   n.ccr[0] = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_CCR1:   n.ccr[1] = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_CCR2:   n.ccr[2] = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_CCR3:   n.ccr[3] = i_pwdata[15:0];
        pwm_capture_timer_pkg::OFF_DEAD:   n.dead = i_pwdata[7:0];
        default:                           n.dead = s.dead;
      endcase
    end
    // capture pins pass two flops before anything looks at them; the trigger input is edge-detected unsynced
    n.sync1 = i_cap;
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    n.trig_prev = i_trig_in;
    enc = s.ctrl[pwm_capture_timer_pkg::CTRL_ENC];
    hall = s.ctrl[pwm_capture_timer_pkg::CTRL_HALL];
    reduced = s.ctrl[pwm_capture_timer_pkg::CTRL_REDUCED];
    frozen = s.ctrl[pwm_capture_timer_pkg::CTRL_FREEZE] & i_dbg_halt;
    run = s.ctrl[pwm_capture_timer_pkg::CTRL_EN] & ~frozen;
    // prescaler divides by presc+1, so 1 through 65536
    // >= so that a presc lowered under the running count ends the period
    tick = 1'b0;
    if (run) begin
      if (s.psc >= s.presc) begin
        n.psc = 16'h0000;
        tick = 1'b1;
      end else begin
        n.psc = s.psc + 16'h0001;
      end
    end
    cmode = reduced ? pwm_capture_timer_pkg::CNT_UP
                    : s.ctrl[pwm_capture_timer_pkg::CTRL_DIR +: 2];
    upd_evt = 1'b0;
    // x4 quadrature decode: a new level of a against the old level of b
    enc_step = run & enc & ((s.sync2[0] ^ s.prev[0]) | (s.sync2[1] ^ s.prev[1]));
    enc_up = s.sync2[0] ^ s.prev[1];
    if (enc) begin
      if (enc_step) begin
        if (enc_up) begin
          n.cnt = (s.cnt >= s.reload) ? 16'h0000 : s.cnt + 16'h0001;
        end else begin
          n.cnt = (s.cnt == 16'h0000) ? s.reload : s.cnt - 16'h0001;
        end
      end
    end else if (tick) begin
      if (cmode == pwm_capture_timer_pkg::CNT_DOWN) begin
        if (s.cnt == 16'h0000) begin
          n.cnt = s.reload;
          upd_evt = 1'b1;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end else if (cmode == pwm_capture_timer_pkg::CNT_CENTER) begin
        if (s.dir == pwm_capture_timer_pkg::DIR_UP) begin
          if (s.cnt >= s.reload) begin
            n.dir = pwm_capture_timer_pkg::DIR_DOWN;
            n.cnt = (s.reload == 16'h0000) ? 16'h0000
                                           : s.reload - 16'h0001;
            upd_evt = 1'b1;
          end else begin
            n.cnt = s.cnt + 16'h0001;
          end
        end else begin
          if (s.cnt == 16'h0000) begin
            n.dir = pwm_capture_timer_pkg::DIR_UP;
            n.cnt = (s.reload == 16'h0000) ? 16'h0000 : 16'h0001;
            upd_evt = 1'b1;
          end else begin
            n.cnt = s.cnt - 16'h0001;
          end
        end
      end else begin
        // a reload lowered below the count still wraps at once
        if (s.cnt >= s.reload) begin
          n.cnt = 16'h0000;
          upd_evt = 1'b1;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
    end
    if (upd_evt & s.ctrl[pwm_capture_timer_pkg::CTRL_OPM]) begin
      n.ctrl[pwm_capture_timer_pkg::CTRL_EN] = 1'b0;
    end
    trig_evt = i_trig_in & ~s.trig_prev;
    if (trig_evt & s.ctrl[pwm_capture_timer_pkg::CTRL_SLAVE]) begin
      n.ctrl[pwm_capture_timer_pkg::CTRL_EN] = 1'b1;
    end
    n.trig_o = upd_evt;
    // hall sensors: any change of any input flips the parity
    hall_evt = hall & ((^s.sync2[2:0]) ^ (^s.prev[2:0]));
    cap_evt = 4'h0;
    cc_set = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m = s.chmode[i*4 +: 2];
      pol = s.chmode[i*4 + pwm_capture_timer_pkg::CH_POL];
      oe = s.chmode[i*4 + pwm_capture_timer_pkg::CH_OE];
      rise = s.sync2[i] & ~s.prev[i];
      fall = ~s.sync2[i] & s.prev[i];
      if (m == pwm_capture_timer_pkg::CH_CAPTURE) begin
        cap_evt[i] = pol ? fall : rise;
        n.lvl[i] = 1'b0;
        if (cap_evt[i]) begin
          n.ccr[i] = s.cnt;
          cc_set[i] = 1'b1;
        end
      end else if (m == pwm_capture_timer_pkg::CH_COMPARE) begin
        if (tick && s.cnt == s.ccr[i]) begin
          n.lvl[i] = ~s.lvl[i];
          cc_set[i] = 1'b1;
        end
      end else begin
        // count below compare: ccr 0 is always off, ccr above reload on
        n.lvl[i] = (s.cnt < s.ccr[i]);
        cc_set[i] = tick && s.cnt == s.ccr[i];
      end
      lv = (s.lvl[i] ^ pol) & oe & (m != pwm_capture_timer_pkg::CH_CAPTURE);
      if (i < 3) begin
        n.outp[i] = lv & (s.dt[i % 3] == 8'h00) & (~reduced | i < 2);
        n.outn[i % 3] = oe & (m != pwm_capture_timer_pkg::CH_CAPTURE)
                      & ~(s.lvl[i] ^ pol) & (s.dt[i % 3] == 8'h00)
                      & (~reduced | i == 0);
      end else begin
        n.outp[i] = lv & ~reduced;
      end
    end
    // both sides of a pair stay low for dead cycles after each flip
    for (int j = 0; j < 3; j++) begin
      if (n.lvl[j] != s.lvl[j]) begin
        n.dt[j] = s.dead;
      end else if (s.dt[j] != 8'h00) begin
        n.dt[j] = s.dt[j] - 8'h01;
      end
    end
    if (hall_evt) begin
      n.ccr[0] = s.cnt;
      n.cnt = 16'h0000;
    end
    // software writes to the count win over counting in that cycle
    if (cnt_wr) begin
      n.cnt = i_pwdata[15:0];
    end
    st_set = {hall_evt, trig_evt, cc_set, upd_evt};
    // a flag raised in its clearing cycle survives
    n.status = (s.status & ~st_clr) | st_set;
    n.dmareq = {cc_set, upd_evt} & s.dma;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
      s.reload <= pwm_capture_timer_pkg::RELOAD_RST;
      s.dir <= pwm_capture_timer_pkg::DIR_UP;
    end else begin
      s <= n;
    end
  end

  assign o_prdata = s.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = s.slverr & i_psel & i_penable;
  assign o_ch = s.outp;
  assign o_chn = s.outn;
  assign o_trig_out = s.trig_o;
  assign o_dma_req = s.dmareq;
  assign o_irq = |(s.status & s.mask);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_pair_flip;
    $changed(s.lvl[0]) && s.dt[0] != 8'h00;
  endsequence

  a_psc_divide:
    assert property (run && s.psc < s.presc
                     |=> s.psc == $past(s.psc) + 16'h0001)
      else $error("prescaler skipped a count");
  a_up_wrap:
    assert property (tick && !enc && !hall && !cnt_wr
                     && cmode == pwm_capture_timer_pkg::CNT_UP
                     && s.cnt == s.reload
                     |=> s.cnt == 16'h0000 && s.status[0] && o_trig_out)
      else $error("up count did not reload with update");
  a_count_freeze:
    assert property (frozen && !cnt_wr && !hall_evt |=> $stable(s.cnt))
      else $error("counter moved during debug halt");
  a_capture_latch:
    assert property (cap_evt[1] |=> s.ccr[1] == $past(s.cnt) && s.status[2])
      else $error("capture did not latch count");
  a_pwm_high:
    assert property (s.chmode[13:12] == pwm_capture_timer_pkg::CH_PWM
                     && s.cnt < s.ccr[3] |=> s.lvl[3])
      else $error("pwm level low below compare");
  a_pwm_low:
    assert property (s.chmode[13:12] == pwm_capture_timer_pkg::CH_PWM
                     && s.cnt >= s.ccr[3] |=> !s.lvl[3])
      else $error("pwm level high at or above compare");
  a_dead_gap:
    assert property (s_pair_flip |=> !o_ch[0] && !o_chn[0])
      else $error("pair switched inside dead time");
  a_no_overlap:
    assert property (!(o_ch[1] && o_chn[1]) && !(o_ch[2] && o_chn[2]))
      else $error("complementary pair both high");
  a_reduced_up:
    assert property (reduced && tick && !enc && !hall && !cnt_wr
                     && s.cnt < s.reload
                     |=> s.cnt == $past(s.cnt) + 16'h0001)
      else $error("reduced variant did not count up");
  a_dma_update:
    assert property (upd_evt && s.dma[0]
                     |=> o_dma_req[0] ##1 (!o_dma_req[0] || $past(upd_evt)))
      else $error("update dma request missing");
  a_trig_start:
    assert property (trig_evt && s.ctrl[pwm_capture_timer_pkg::CTRL_SLAVE]
                     && !wr
                     |=> s.ctrl[pwm_capture_timer_pkg::CTRL_EN])
      else $error("trigger did not start counter");
  a_enc_up:
    assert property (enc_step && enc_up && !cnt_wr && !hall_evt
                     && s.cnt < s.reload
                     |=> s.cnt == $past(s.cnt) + 16'h0001)
      else $error("encoder forward step lost");
  a_hall_reset:
    assert property (hall_evt && !cnt_wr
                     |=> s.cnt == 16'h0000 && s.status[6])
      else $error("hall change did not restart count");
  a_hall_latch:
    assert property (hall_evt |=> s.ccr[0] == $past(s.cnt))
      else $error("hall change did not latch count");
  a_psc_wrap:
    assert property (run && s.psc >= s.presc |=> s.psc == 16'h0000)
      else $error("prescaler did not restart");
  a_down_reload:
    assert property (tick && !enc && !hall && !cnt_wr
                     && cmode == pwm_capture_timer_pkg::CNT_DOWN
                     && s.cnt == 16'h0000
                     |=> s.cnt == $past(s.reload) && s.status[0])
      else $error("down count did not reload with update");
  a_compare_toggle:
    assert property (tick && s.cnt == s.ccr[0]
                     && s.chmode[1:0] == pwm_capture_timer_pkg::CH_COMPARE
                     |=> s.lvl[0] != $past(s.lvl[0]))
      else $error("compare match did not toggle output");
  // one-pulse stop yields to a trigger start in the same cycle
  a_one_pulse:
    assert property (upd_evt && s.ctrl[pwm_capture_timer_pkg::CTRL_OPM]
                     && !trig_evt
                     |=> !s.ctrl[pwm_capture_timer_pkg::CTRL_EN])
      else $error("one-pulse run did not stop");
  a_reduced_off:
    assert property (reduced |=> !o_ch[2] && !o_ch[3] && o_chn[2:1] == 2'h0)
      else $error("reduced variant drove a missing output");
endmodule
`default_nettype wire

// [inc/pwm_capture_timer_pkg.sv]
package pwm_capture_timer_pkg;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_PRESC   = 8'h04;
  localparam logic [7:0]  OFF_RELOAD  = 8'h08;
  localparam logic [7:0]  OFF_COUNT   = 8'h0C;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_MASK    = 8'h14;
  localparam logic [7:0]  OFF_DMA     = 8'h18;
  localparam logic [7:0]  OFF_CHMODE  = 8'h1C;
  localparam logic [7:0]  OFF_CCR0    = 8'h20;
  localparam logic [7:0]  OFF_CCR1    = 8'h24;
  localparam logic [7:0]  OFF_CCR2    = 8'h28;
  localparam logic [7:0]  OFF_CCR3    = 8'h2C;
  localparam logic [7:0]  OFF_DEAD    = 8'h30;
  localparam int          CTRL_EN      = 0;
  localparam int          CTRL_DIR     = 1;
  localparam int          CTRL_OPM     = 3;
  localparam int          CTRL_FREEZE  = 4;
  localparam int          CTRL_REDUCED = 5;
  localparam int          CTRL_ENC     = 6;
  localparam int          CTRL_HALL    = 7;
  localparam int          CTRL_SLAVE   = 8;
  localparam int          CTRL_W       = 9;
  localparam logic [1:0]  CNT_UP       = 2'h0;
  localparam logic [1:0]  CNT_DOWN     = 2'h1;
  localparam logic [1:0]  CNT_CENTER   = 2'h2;
  localparam logic [1:0]  CH_CAPTURE   = 2'h0;
  localparam logic [1:0]  CH_COMPARE   = 2'h1;
  localparam logic [1:0]  CH_PWM       = 2'h2;
  localparam int          CH_POL       = 2;
  localparam int          CH_OE        = 3;
  localparam int          CH_W         = 4;
  localparam int          ST_UPD       = 0;
  localparam int          ST_CC0       = 1;
  localparam int          ST_TRIG      = 5;
  localparam int          ST_HALL      = 6;
  localparam int          ST_W         = 7;
  localparam int          DMA_W        = 5;
  localparam int          NCH          = 4;
  localparam int          NCOMP        = 3;
  localparam logic [15:0] RELOAD_RST   = 16'hFFFF;
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } cnt_dir_t;
  typedef struct packed {
    logic [CTRL_W-1:0]       ctrl;
    logic [15:0]             presc;
    logic [15:0]             reload;
    logic [15:0]             cnt;
    logic [15:0]             psc;
    cnt_dir_t                dir;
    logic [ST_W-1:0]         status;
    logic [ST_W-1:0]         mask;
    logic [DMA_W-1:0]        dma;
    logic [DMA_W-1:0]        dmareq;
    logic [15:0]             chmode;
    logic [NCH-1:0][15:0]    ccr;
    logic [7:0]              dead;
    logic [NCOMP-1:0][7:0]   dt;
    logic [NCH-1:0]          lvl;
    logic [NCH-1:0]          outp;
    logic [NCOMP-1:0]        outn;
    logic [NCH-1:0]          sync1;
    logic [NCH-1:0]          sync2;
    logic [NCH-1:0]          prev;
    logic                    trig_prev;
    logic                    trig_o;
    logic [31:0]             rdata;
    logic                    slverr;
  } timer_state_t;
endpackage
